// >>> hw/floppy_cmd_pkg.sv
package floppy_cmd_pkg;

    typedef enum logic [3:0] {
        ST_DONE, ST_INIT, ST_WC, ST_BA, ST_FETCH, ST_STORE, ST_RELEASE,
        ST_ZERO, ST_SA, ST_TA, ST_SEARCH, ST_WRITE, ST_CRC, ST_POWER
    } state_type;

    // Drive-side pins, all asynchronous to core_clk
    typedef struct packed {
        logic ready;
        logic double_sided;
        logic density;
        logic power_lost;
        logic index;
        logic sector_found;
        logic crc_fail;
        logic deleted_mark;
    } drive_status_type;

    // DMA master request toward memory
    typedef struct packed {
        logic strobe;
        logic write;
        logic [17:0] addr;
        logic [15:0] data;
    } dma_out_type;

endpackage : floppy_cmd_pkg

// >>> hw/floppy_cmd_regs.svh
`ifndef FLOPPY_CMD_REGS_SVH
`define FLOPPY_CMD_REGS_SVH

// Register select on the host port
`define SEL_CMD 1'b0
`define SEL_DATA 1'b1

// Command and state register fields
`define CS_GO 0
`define CS_FN_LO 1
`define CS_FN_HI 3
`define CS_UNIT 4
`define CS_DONE 5
`define CS_IE 6
`define CS_TR 7
`define CS_DEN 8
`define CS_HEAD 9
`define CS_TYPE 11
`define CS_XA_LO 12
`define CS_XA_HI 13
`define CS_INIT 14
`define CS_ERR 15

// Error and drive status fields
`define ES_CRC 0
`define ES_SIDE1 1
`define ES_INIT_DONE 2
`define ES_PWR_LOST 3
`define ES_DEN_ERR 4
`define ES_DRV_DEN 5
`define ES_DEL_MARK 6
`define ES_DRV_RDY 7
`define ES_UNIT 8
`define ES_WC_OVF 10
`define ES_NXM 11
`define ES_WIDTH 12
`define ES_RESET 12'h000

// Function codes
`define FN_FILL 3'h0
`define FN_EMPTY 3'h1
`define FN_WRITE 3'h2
`define FN_RDSTAT 3'h5

// Geometry and sector sizes in words
`define WORDS_DOUBLE 8'h80
`define WORDS_SINGLE 8'h40
`define TRACK_COUNT 7'h4D
`define SECTOR_COUNT 5'h1A
`define SEARCH_REVS 2'h2

// Timing
`define CLK_PERIOD_NS 25
`define DMA_TIMEOUT_NS 10000
`define DMA_TIMEOUT_CYC ((`DMA_TIMEOUT_NS) / (`CLK_PERIOD_NS))

`endif

// >>> hw/floppy_command_protocol.sv
`include "floppy_cmd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module floppy_command_protocol
    import floppy_cmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host register port
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic irq,
    // DMA master
    output dma_out_type dma_out,
    input wire logic dma_reply,
    input wire logic [15:0] dma_rdata,
    // Drive
    input wire drive_status_type drive_in,
    output logic [6:0] track_out,
    output logic [4:0] sector_out,
    output logic unit_out,
    output logic head_out,
    output logic drive_word_valid,
    output logic drive_crc_valid,
    output logic [15:0] drive_word
);

    function automatic logic [7:0] word_limit(input logic den);
        word_limit = den ? `WORDS_DOUBLE : `WORDS_SINGLE;
    endfunction : word_limit

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] w);
        logic [15:0] c;
        logic fb;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            fb = c[15] ^ w[i];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        crc_step = c;
    endfunction : crc_step

    state_type state_r;
    drive_status_type drv_meta_r, drv_s_r, drv_prev_r;
    logic reply_meta_r, reply_s_r;
    logic [1:0] settle_r;
    logic done_r, err_r, ie_r, tr_r, done_prev_r;
    logic [2:0] fn_r;
    logic den_r, head_r, unit_r;
    logic [1:0] xa_r;
    logic [`ES_WIDTH-1:0] es_r;
    logic [15:0] wc_r;
    logic [17:0] ba_r;
    logic [7:0] idx_r;
    logic [8:0] timer_r;
    logic [1:0] revs_r;
    logic [15:0] crc_r;
    logic [15:0] sector_buf [0:127];
    logic [15:0] buf_word;
    logic buf_we;
    logic [15:0] buf_wd;
    logic cmd_wr, data_wr;
    logic index_rise, found_rise, crc_rise, del_rise, pwr_rise;
    logic [7:0] limit;
    logic [8:0] dma_limit;

    // Pins pass two flops before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_meta_r <= '0;
            drv_s_r <= '0;
            drv_prev_r <= '0;
            reply_meta_r <= 1'b0;
            reply_s_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            drv_meta_r <= drive_in;
            drv_s_r <= drv_meta_r;
            drv_prev_r <= drv_s_r;
            reply_meta_r <= dma_reply;
            reply_s_r <= reply_meta_r;
            // Init must not read the reset zeros still in the flops
            settle_r <= settle_r | {settle_r[0], 1'b1};
        end
    end

    assign index_rise = drv_s_r.index & ~drv_prev_r.index;
    assign found_rise = drv_s_r.sector_found & ~drv_prev_r.sector_found;
    assign crc_rise = drv_s_r.crc_fail & ~drv_prev_r.crc_fail;
    assign del_rise = drv_s_r.deleted_mark & ~drv_prev_r.deleted_mark;
    assign pwr_rise = drv_s_r.power_lost & ~drv_prev_r.power_lost;
    assign cmd_wr = reg_wr & (reg_sel == `SEL_CMD);
    assign data_wr = reg_wr & (reg_sel == `SEL_DATA);
    assign limit = word_limit(den_r);
    assign dma_limit = 9'(`DMA_TIMEOUT_CYC);
    assign buf_word = sector_buf[idx_r[6:0]];

    // Fill path writes DMA data, then zeros past the count
    always_comb begin
        buf_we = 1'b0;
        buf_wd = 16'h0000;
        if (state_r == ST_FETCH && reply_s_r) begin
            buf_we = 1'b1;
            buf_wd = dma_rdata;
        end else if (state_r == ST_ZERO && idx_r < limit) begin
            buf_we = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            sector_buf[idx_r[6:0]] <= buf_wd;
        end
    end

    // Function sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_INIT;
            done_r <= 1'b0;
            err_r <= 1'b0;
            ie_r <= 1'b0;
            tr_r <= 1'b0;
            fn_r <= `FN_FILL;
            den_r <= 1'b0;
            head_r <= 1'b0;
            unit_r <= 1'b0;
            xa_r <= 2'h0;
            es_r <= `ES_RESET;
            wc_r <= 16'h0000;
            ba_r <= 18'h00000;
            idx_r <= 8'h00;
            timer_r <= 9'h000;
            revs_r <= 2'h0;
            crc_r <= 16'hFFFF;
            track_out <= 7'h00;
            sector_out <= 5'h00;
            dma_out <= '0;
            drive_word_valid <= 1'b0;
            drive_crc_valid <= 1'b0;
            drive_word <= 16'h0000;
        end else begin
            drive_word_valid <= 1'b0;
            drive_crc_valid <= 1'b0;
            if (pwr_rise) begin
                // Power loss aborts whatever runs
                es_r[`ES_PWR_LOST] <= 1'b1;
                err_r <= 1'b1;
                done_r <= 1'b1;
                tr_r <= 1'b0;
                dma_out <= '0;
                state_r <= ST_POWER;
            end else begin
                case (state_r)
                    ST_DONE: begin
                        if (cmd_wr) begin
                            ie_r <= reg_wdata[`CS_IE];
                            if (reg_wdata[`CS_INIT]) begin
                                done_r <= 1'b0;
                                state_r <= ST_INIT;
                            end else if (reg_wdata[`CS_GO]) begin
                                fn_r <= reg_wdata[`CS_FN_HI:`CS_FN_LO];
                                den_r <= reg_wdata[`CS_DEN];
                                head_r <= reg_wdata[`CS_HEAD];
                                unit_r <= reg_wdata[`CS_UNIT];
                                xa_r <= reg_wdata[`CS_XA_HI:`CS_XA_LO];
                                err_r <= 1'b0;
                                done_r <= 1'b0;
                                case (reg_wdata[`CS_FN_HI:`CS_FN_LO])
                                    `FN_FILL, `FN_EMPTY: begin
                                        tr_r <= 1'b1;
                                        state_r <= ST_WC;
                                    end
                                    `FN_WRITE: begin
                                        // Drive-ready survives the clear
                                        es_r <= `ES_RESET;
                                        es_r[`ES_DRV_RDY] <= es_r[`ES_DRV_RDY];
                                        tr_r <= 1'b1;
                                        state_r <= ST_SA;
                                    end
                                    `FN_RDSTAT: begin
                                        state_r <= ST_INIT;
                                    end
                                    default: begin
                                        done_r <= 1'b1;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_INIT: begin
                        // Only place drive-ready and side refresh; density also refreshes on a found sector
                        if (settle_r[1]) begin
                            es_r[`ES_DRV_RDY] <= drv_s_r.ready;
                            es_r[`ES_SIDE1] <= drv_s_r.ready & drv_s_r.double_sided;
                            es_r[`ES_DRV_DEN] <= drv_s_r.density;
                            if (fn_r != `FN_RDSTAT) begin
                                es_r[`ES_CRC] <= 1'b0;
                                es_r[`ES_DEN_ERR] <= 1'b0;
                                es_r[`ES_DEL_MARK] <= 1'b0;
                                es_r[`ES_WC_OVF] <= 1'b0;
                                es_r[`ES_NXM] <= 1'b0;
                                es_r[`ES_PWR_LOST] <= 1'b0;
                                es_r[`ES_INIT_DONE] <= 1'b1;
                                err_r <= 1'b0;
                            end
                            fn_r <= `FN_FILL;
                            done_r <= 1'b1;
                            state_r <= ST_DONE;
                        end
                    end
                    ST_WC: begin
                        if (data_wr) begin
                            wc_r <= reg_wdata;
                            tr_r <= 1'b0;
                            if (reg_wdata > {8'h00, limit}) begin
                                es_r[`ES_WC_OVF] <= 1'b1;
                                err_r <= 1'b1;
                                done_r <= 1'b1;
                                state_r <= ST_DONE;
                            end else begin
                                state_r <= ST_BA;
                            end
                        end
                    end
                    ST_BA: begin
                        // Request falls for one cycle between words
                        tr_r <= ~data_wr;
                        if (data_wr) begin
                            ba_r <= {xa_r, reg_wdata};
                            idx_r <= 8'h00;
                            timer_r <= 9'h000;
                            if (wc_r == 16'h0000) begin
                                state_r <= (fn_r == `FN_FILL) ? ST_ZERO : ST_DONE;
                                done_r <= (fn_r != `FN_FILL);
                            end else begin
                                state_r <= (fn_r == `FN_FILL) ? ST_FETCH : ST_STORE;
                            end
                        end
                    end
                    ST_FETCH, ST_STORE: begin
                        dma_out.strobe <= 1'b1;
                        dma_out.write <= (state_r == ST_STORE);
                        dma_out.addr <= ba_r;
                        dma_out.data <= buf_word;
                        timer_r <= timer_r + 9'h001;
                        if (reply_s_r) begin
                            dma_out.strobe <= 1'b0;
                            state_r <= ST_RELEASE;
                        end else if (timer_r == dma_limit) begin
                            es_r[`ES_NXM] <= 1'b1;
                            err_r <= 1'b1;
                            done_r <= 1'b1;
                            dma_out <= '0;
                            state_r <= ST_DONE;
                        end
                    end
                    ST_RELEASE: begin
                        if (!reply_s_r) begin
                            ba_r <= ba_r + 18'h00002;
                            wc_r <= wc_r - 16'h0001;
                            idx_r <= idx_r + 8'h01;
                            timer_r <= 9'h000;
                            if (wc_r == 16'h0001) begin
                                state_r <= (fn_r == `FN_FILL) ? ST_ZERO : ST_DONE;
                                done_r <= (fn_r != `FN_FILL);
                            end else begin
                                state_r <= (fn_r == `FN_FILL) ? ST_FETCH : ST_STORE;
                            end
                        end
                    end
                    ST_ZERO: begin
                        if (idx_r < limit) begin
                            idx_r <= idx_r + 8'h01;
                        end else begin
                            done_r <= 1'b1;
                            state_r <= ST_DONE;
                        end
                    end
                    ST_SA: begin
                        if (data_wr) begin
                            sector_out <= reg_wdata[4:0];
                            tr_r <= 1'b0;
                            state_r <= ST_TA;
                        end
                    end
                    ST_TA: begin
                        tr_r <= ~data_wr;
                        if (data_wr) begin
                            track_out <= reg_wdata[6:0];
                            revs_r <= 2'h0;
                            state_r <= ST_SEARCH;
                        end
                    end
                    ST_SEARCH: begin
                        if (found_rise) begin
                            es_r[`ES_DRV_DEN] <= drv_s_r.density;
                            if (drv_s_r.density != den_r) begin
                                es_r[`ES_DEN_ERR] <= 1'b1;
                                err_r <= 1'b1;
                                done_r <= 1'b1;
                                state_r <= ST_DONE;
                            end else begin
                                idx_r <= 8'h00;
                                crc_r <= 16'hFFFF;
                                state_r <= ST_WRITE;
                            end
                        end else if (index_rise) begin
                            revs_r <= revs_r + 2'h1;
                            if (revs_r + 2'h1 == `SEARCH_REVS) begin
                                err_r <= 1'b1;
                                done_r <= 1'b1;
                                state_r <= ST_DONE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        // Buffer is only read here, so it stays intact
                        drive_word <= buf_word;
                        drive_word_valid <= 1'b1;
                        crc_r <= crc_step(crc_r, buf_word);
                        idx_r <= idx_r + 8'h01;
                        if (idx_r == limit - 8'h01) begin
                            state_r <= ST_CRC;
                        end
                    end
                    ST_CRC: begin
                        drive_word <= crc_r;
                        drive_crc_valid <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= ST_DONE;
                    end
                    ST_POWER: begin
                        if (!drv_s_r.power_lost) begin
                            done_r <= 1'b0;
                            fn_r <= `FN_FILL;
                            state_r <= ST_INIT;
                        end
                    end
                    default: begin
                        state_r <= ST_DONE;
                    end
                endcase
                // Drive reports while a function runs
                if (!done_r && crc_rise) begin
                    es_r[`ES_CRC] <= 1'b1;
                end
                if (!done_r && del_rise) begin
                    es_r[`ES_DEL_MARK] <= 1'b1;
                end
            end
            es_r[`ES_UNIT] <= unit_r;
        end
    end

    // Host reads; status stands in the data port once complete
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_sel == `SEL_CMD) begin
                reg_rdata <= 16'h0000;
                reg_rdata[`CS_ERR] <= err_r;
                reg_rdata[`CS_TYPE] <= 1'b1;
                reg_rdata[`CS_HEAD] <= done_r & head_r;
                reg_rdata[`CS_DEN] <= done_r & den_r;
                reg_rdata[`CS_TR] <= tr_r;
                reg_rdata[`CS_IE] <= ie_r;
                reg_rdata[`CS_DONE] <= done_r;
                reg_rdata[`CS_UNIT] <= done_r & unit_r;
            end else begin
                reg_rdata <= done_r ? {4'h0, es_r} : 16'h0000;
            end
        end
    end

    // Interrupt pulse on the rise of completion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_prev_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            done_prev_r <= done_r;
            irq <= done_r & ~done_prev_r & ie_r;
        end
    end

    assign unit_out = unit_r;
    assign head_out = head_r;

endmodule : floppy_command_protocol

`default_nettype wire

// >>> sim/dma_memory_model.sv
`timescale 1ns/1ps
`default_nettype none

module dma_memory_model
    import floppy_cmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus side
    input wire dma_out_type dma_out,
    output logic dma_reply,
    output logic [15:0] dma_rdata,
    // Behaviour
    input wire logic [3:0] delay,
    input wire logic absent
);
    logic [3:0] wait_r;
    logic junk_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 4'h0;
            dma_reply <= 1'b0;
        end else if (!dma_out.strobe) begin
            wait_r <= 4'h0;
            dma_reply <= 1'b0;
        end else if (!absent && wait_r >= delay) begin
            dma_reply <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end

    // Idle bus toggles so stale data never passes for a word
    always_ff @(posedge core_clk) begin
        junk_r <= ~junk_r;
    end
    assign dma_rdata = dma_reply ? (dma_out.addr[15:0] ^ 16'hC35A) : {16{junk_r}};
endmodule : dma_memory_model

`default_nettype wire

// >>> sim/floppy_cmd_checker.sv
`timescale 1ns/1ps
`default_nettype none

module floppy_cmd_checker
    import floppy_cmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched outputs
    input wire logic irq,
    input wire dma_out_type dma_out,
    input wire logic drive_word_valid,
    input wire logic drive_crc_valid,
    input wire logic [6:0] track_out,
    input wire logic [4:0] sector_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] word_cnt_r;
    logic [9:0] hold_cnt_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) word_cnt_r <= 8'h00;
        else if (drive_crc_valid) word_cnt_r <= 8'h00;
        else if (drive_word_valid) word_cnt_r <= word_cnt_r + 8'h01;
    end

    // Counted, since a long repetition would crawl
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) hold_cnt_r <= 10'h000;
        else if (dma_out.strobe) hold_cnt_r <= hold_cnt_r + 10'h001;
        else hold_cnt_r <= 10'h000;
    end

    sequence burst_start;
        $rose(drive_word_valid);
    endsequence
    sequence burst_run;
        drive_word_valid [*8];
    endsequence

    a_strobe_holds: assert property ($rose(dma_out.strobe) |-> dma_out.strobe [*3])
        else $error("strobe dropped early");
    a_request_steady: assert property (dma_out.strobe && $past(dma_out.strobe) |->
        $stable(dma_out.addr) && $stable(dma_out.data))
        else $error("dma request moved");
    a_reply_bound: assert property (hold_cnt_r <= 10'd405)
        else $error("strobe held too long");
    a_irq_pulse: assert property (irq |=> !irq)
        else $error("irq not a pulse");
    a_burst_length: assert property (burst_start |-> burst_run)
        else $error("short word burst");
    a_crc_count: assert property (drive_crc_valid |->
        word_cnt_r == 8'd64 || word_cnt_r == 8'd128)
        else $error("bad word count before crc");
    a_crc_follows: assert property (drive_crc_valid |->
        $past(drive_word_valid) && !drive_word_valid)
        else $error("crc out of place");
    a_place_steady: assert property (drive_word_valid |->
        $stable(track_out) && $stable(sector_out))
        else $error("place moved while writing");
    a_no_dma_mix: assert property (drive_word_valid |-> !dma_out.strobe)
        else $error("dma during sector write");
endmodule : floppy_cmd_checker

bind floppy_command_protocol floppy_cmd_checker u_chk (.core_clk, .rst_n, .irq, .dma_out,
    .drive_word_valid, .drive_crc_valid, .track_out, .sector_out);

`default_nettype wire

// >>> sim/floppy_command_protocol_test.sv
`timescale 1ns/1ps
`default_nettype none

module floppy_command_protocol_test
    import floppy_cmd_pkg::*;
;
    logic core_clk, rst_n, reg_sel, reg_wr, reg_rd, irq, dma_reply, absent;
    logic unit_out, head_out, drive_word_valid, drive_crc_valid, want, pend, stb_d;
    logic [15:0] reg_wdata, reg_rdata, dma_rdata, drive_word, base, v, m, crc;
    logic [15:0] exp_q[$], mask_q[$], addr_q[$], word_q[$], buf_w[0:127];
    logic [6:0] track_out, t;
    logic [4:0] sector_out, s;
    logic [3:0] delay;
    dma_out_type dma_out;
    drive_status_type drive_in;
    int failures, tests_run, irq_cnt, cycles, wc, n;

    floppy_command_protocol DUT (.core_clk, .rst_n, .reg_sel, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .irq, .dma_out, .dma_reply, .dma_rdata, .drive_in, .track_out,
        .sector_out, .unit_out, .head_out, .drive_word_valid, .drive_crc_valid, .drive_word);
    dma_memory_model u_mem (.core_clk, .rst_n, .dma_out, .dma_reply, .dma_rdata, .delay,
        .absent);

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic sel, input logic [15:0] d);
        @(posedge core_clk);
        #2;
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #2;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic sel, input logic c);
        @(posedge core_clk);
        #2;
        reg_sel = sel;
        reg_rd = 1'b1;
        want = c;
        @(posedge core_clk);
        #2;
        reg_rd = 1'b0;
        @(posedge core_clk);
        #2;
        v = reg_rdata;
    endtask : rd

    task automatic chk(input logic sel, input logic [15:0] e, input logic [15:0] mk);
        exp_q.push_back(e);
        mask_q.push_back(mk);
        rd(sel, 1'b1);
    endtask : chk

    task automatic wait_bit(input int b);
        v = 16'h0000;
        for (int k = 0; k < 3000 && v[b] !== 1'b1; k++) rd(1'b0, 1'b0);
    endtask : wait_bit

    task automatic proto(input logic [15:0] a, input logic [15:0] b);
        wait_bit(7);
        wr(1'b1, a);
        wait_bit(7);
        wr(1'b1, b);
    endtask : proto

    task automatic pulse(input int i);
        @(posedge core_clk);
        #2;
        drive_in[i] = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        drive_in[i] = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pulse

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
        if (irq) irq_cnt++;
        if (pend) begin
            m = mask_q.pop_front();
            check("rdata", reg_rdata & m, exp_q.pop_front());
        end
        if (dma_out.strobe && !stb_d) begin
            check("dma addr", dma_out.addr, {2'b00, addr_q.pop_front()});
            if (dma_out.write) check("dma data", dma_out.data, word_q.pop_front());
        end
        if (drive_word_valid) check("drive word", drive_word, word_q.pop_front());
        if (drive_crc_valid) check("crc word", drive_word, word_q.pop_front());
        pend <= reg_rd && want;
        stb_d <= dma_out.strobe;
    end

    initial begin
        {core_clk, rst_n, reg_sel, reg_wr, reg_rd, absent, want, pend, stb_d} = '0;
        reg_wdata = 16'h0000;
        delay = 4'h2;
        drive_in = 8'hE0;
        void'($urandom(38));
        repeat (10) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        chk(1'b1, 16'h00A6, 16'h0DFF);
        chk(1'b0, 16'h0820, 16'h8820);
        wc = $urandom_range(128, 1);
        base = 16'h1000 + 16'($urandom_range(1000, 0) * 2);
        for (int k = 0; k < 128; k++) begin
            buf_w[k] = (k < wc) ? ((base + 16'(2 * k)) ^ 16'hC35A) : 16'h0000;
            if (k < wc) addr_q.push_back(base + 16'(2 * k));
        end
        n = irq_cnt;
        wr(1'b0, 16'h0141);
        wr(1'b0, 16'h0003);
        proto(16'(wc), base);
        chk(1'b1, 16'h0000, 16'hFFFF);
        wait_bit(5);
        chk(1'b1, 16'h0000, 16'h0C10);
        chk(1'b0, 16'h0020, 16'h8020);
        check("irq count", 18'(irq_cnt - n), 18'd1);
        delay = 4'($urandom_range(5, 1));
        base = base + 16'h4000;
        for (int k = 0; k < wc; k++) begin
            addr_q.push_back(base + 16'(2 * k));
            word_q.push_back(buf_w[k]);
        end
        wr(1'b0, 16'h0103);
        proto(16'(wc), base);
        wait_bit(5);
        chk(1'b1, 16'h0000, 16'h0C10);
        s = 5'($urandom_range(25, 0));
        t = 7'($urandom_range(76, 0));
        for (int k = 0; k < 128; k++) word_q.push_back(buf_w[k]);
        crc = 16'hFFFF;
        for (int k = 0; k < 2048; k++) begin
            v = {crc[14:0], 1'b0};
            crc = (crc[15] ^ buf_w[k / 16][15 - k % 16]) ? v ^ 16'h1021 : v;
        end
        word_q.push_back(crc);
        wr(1'b0, 16'h0145);
        proto({11'h000, s}, {9'h000, t});
        pulse(2);
        wait_bit(5);
        check("track", track_out, t);
        check("sector", sector_out, s);
        chk(1'b1, 16'h0080, 16'h0C9F);
        wr(1'b0, 16'h0045);
        proto({11'h000, s}, {9'h000, t});
        pulse(2);
        wait_bit(5);
        chk(1'b1, 16'h0010, 16'h0010);
        chk(1'b0, 16'h8020, 16'h8020);
        wr(1'b0, 16'h0145);
        proto({11'h000, s}, {9'h000, t});
        pulse(3);
        pulse(3);
        wait_bit(5);
        chk(1'b0, 16'h8020, 16'h8020);
        drive_in.ready = 1'b0;
        wr(1'b0, 16'h0103);
        proto(16'h0000, base);
        wait_bit(5);
        chk(1'b0, 16'h0020, 16'h8020);
        chk(1'b1, 16'h0080, 16'h0080);
        wr(1'b0, 16'h021B);
        wait_bit(5);
        chk(1'b1, 16'h0100, 16'h0180);
        chk(1'b0, 16'h0A30, 16'h8B70);
        check("head unit", {head_out, unit_out}, 18'd3);
        wr(1'b0, 16'h0041);
        wait_bit(7);
        wr(1'b1, 16'd65);
        wait_bit(5);
        chk(1'b1, 16'h0400, 16'h0400);
        chk(1'b0, 16'h8020, 16'h8020);
        absent = 1'b1;
        addr_q.push_back(base);
        wr(1'b0, 16'h0141);
        proto(16'h0001, base);
        wait_bit(5);
        chk(1'b1, 16'h0800, 16'h0800);
        drive_in.power_lost = 1'b1;
        repeat (8) @(posedge core_clk);
        chk(1'b1, 16'h0008, 16'h0008);
        chk(1'b0, 16'h8020, 16'h8020);
        drive_in.power_lost = 1'b0;
        repeat (8) @(posedge core_clk);
        chk(1'b1, 16'h0004, 16'h000C);
        check("queues left", 18'(addr_q.size() + word_q.size()), 18'd0);
        tally_and_finish();
    end
endmodule : floppy_command_protocol_test

`default_nettype wire
